// File: rtl/asc_sequencer.v
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "asc_defines.vh"
module asc_sequencer
#(
  parameter RES_W = 8
)
(
  // ----------------------------------------
  // Clock, reset and stop
  // ----------------------------------------
  input  wire             clk,
  input  wire             reset_n,
  input  wire             hwStop,
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output wire             pready,
  output reg  [31:0]      prdata,
  output wire             pslverr,
  // ----------------------------------------
  // Analog side
  // ----------------------------------------
  input  wire             referenceEnableInput,
  input  wire [7:4]       ainDigital,
  output reg  [2:0]       ainSelect,
  output reg              sampleHold,
  output reg  [RES_W-1:0] dacTrial,
  input  wire             cmpHigh,
  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  output wire             adcDoneIrq
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE   = 2'b00;
  localparam ST_SAMPLE = 2'b01;
  localparam ST_CONV   = 2'b10;
  localparam ST_STORE  = 2'b11;

  reg  [1:0]       state;
  reg  [7:0]       adcChannelMode;
  reg              adcIrqMask;
  reg              adcDoneRequestFlag;
  reg  [7:4]       edgeFlag;
  reg  [1:0]       slotPtr;
  reg  [3:0]       phaseCnt;
  reg  [RES_W-1:0] sar;
  reg  [RES_W-1:0] bitMask;
  reg              refSync1;
  reg              refSync2;
  reg  [7:4]       ainSync1;
  reg  [7:4]       ainSync2;
  reg  [7:4]       ainPrev;
  wire [RES_W-1:0] slotRdData;
  wire             wrAccess;
  wire             rdAccess;
  wire             modeWrite;
  wire             storeNow;
  wire [RES_W-1:0] trial;
  wire [7:4]       fallEdge;

  // Register decode, shared by writes, clears and the read mux
  function hitReg;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hitReg = (addr == offset);
    end
  endfunction

  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign wrAccess = psel & penable & pwrite;
  assign rdAccess = psel & penable & ~pwrite;
  assign modeWrite = wrAccess && hitReg(paddr, `ASC_OFF_MODE);
  assign storeNow = (state == ST_STORE);
  assign trial    = sar | bitMask;
  assign fallEdge = ainPrev & ~ainSync2;
  assign adcDoneIrq = adcDoneRequestFlag & ~adcIrqMask;

  // Input index for a given slot
  function [2:0] pickInput;
    input [7:0] mode;
    input [1:0] slot;
    begin
      if (mode[`ASC_MODE_SCAN_BIT])
      begin
        pickInput = {mode[`ASC_MODE_GROUP_BIT], slot};
      end
      else
      begin
        pickInput = mode[`ASC_MODE_SEL_LSB+2:`ASC_MODE_SEL_LSB];
      end
    end
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      refSync1 <= 1'b0;
      refSync2 <= 1'b0;
      ainSync1 <= 4'h0;
      ainSync2 <= 4'h0;
      ainPrev  <= 4'h0;
    end
    else
    begin
      refSync1 <= referenceEnableInput;
      refSync2 <= refSync1;
      ainSync1 <= ainDigital;
      ainSync2 <= ainSync1;
      ainPrev  <= ainSync2;
    end
  end

  // ----------------------------------------
  // Result slots
  // ----------------------------------------
  // Halted slots are not scrubbed; their contents are simply stale
  asc_slot_mem #(.DATA_W(RES_W), .ADDR_W(2)) slots
  (
    .clk    (clk),
    .wrEn   (storeNow),
    .wrAddr (slotPtr),
    .wrData (sar),
    .rdAddr (paddr[3:2]),
    .rdData (slotRdData)
  );

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= ST_IDLE;
      slotPtr    <= 2'b00;
      phaseCnt   <= 4'h0;
      sar        <= {RES_W{1'b0}};
      bitMask    <= {RES_W{1'b0}};
      ainSelect  <= 3'b000;
      sampleHold <= 1'b0;
      dacTrial   <= {RES_W{1'b0}};
    end
    else if (!refSync2 || modeWrite || hwStop)
    begin
      // Restart from slot 0 in the current mode
      state      <= ST_IDLE;
      slotPtr    <= 2'b00;
      sampleHold <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          ainSelect  <= pickInput(adcChannelMode, slotPtr);
          sampleHold <= 1'b1;
          phaseCnt   <= `ASC_SAMPLE_CYCLES;
          state      <= ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
          if (phaseCnt == 4'h1)
          begin
            sampleHold <= 1'b0;
            sar        <= {RES_W{1'b0}};
            bitMask    <= {1'b1, {(RES_W-1){1'b0}}};
            dacTrial   <= {1'b1, {(RES_W-1){1'b0}}};
            state      <= ST_CONV;
          end
          phaseCnt <= phaseCnt - 4'h1;
        end
        ST_CONV:
        begin
          // Successive approximation, one bit per cycle
          if (cmpHigh)
            sar <= trial;
          bitMask  <= bitMask >> 1;
          dacTrial <= (cmpHigh ? trial : sar) | (bitMask >> 1);
          if (bitMask[0])
            state <= ST_STORE;
        end
        default:
        begin
          slotPtr <= slotPtr + 2'b01;
          state   <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Channel mode register
  // ----------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      adcChannelMode <= `ASC_MODE_RESET;
    else if (hwStop)
      adcChannelMode <= `ASC_MODE_RESET;
    else if (modeWrite)
      adcChannelMode <= {3'b000, pwdata[4:0]};
  end

  // ----------------------------------------
  // Interrupt mask
  // ----------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      adcIrqMask <= `ASC_MASK_RESET;
    else if (hwStop)
      adcIrqMask <= `ASC_MASK_RESET;
    else if (wrAccess && hitReg(paddr, `ASC_OFF_MASK))
      adcIrqMask <= pwdata[0];
  end

  // ----------------------------------------
  // Converter-done flag
  // ----------------------------------------
  // Set wins over write-one-to-clear, so no round is lost
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      adcDoneRequestFlag <= 1'b0;
    else if (storeNow && slotPtr == 2'b11)
      adcDoneRequestFlag <= 1'b1;
    else if (wrAccess && hitReg(paddr, `ASC_OFF_STATUS) && pwdata[0])
      adcDoneRequestFlag <= 1'b0;
  end

  // ----------------------------------------
  // Edge test flags
  // ----------------------------------------
  // Run regardless of reference; a read clears them, a new edge wins
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      edgeFlag <= 4'h0;
    else if (rdAccess && hitReg(paddr, `ASC_OFF_EDGE))
      edgeFlag <= fallEdge;
    else
      edgeFlag <= edgeFlag | fallEdge;
  end

  // ----------------------------------------
  // APB read mux
  // ----------------------------------------
  always @*
  begin
    if (hitReg(paddr, `ASC_OFF_MODE))
    begin
      prdata = {24'h000000, adcChannelMode};
    end
    else if (hitReg(paddr, `ASC_OFF_STATUS))
    begin
      prdata = {31'h00000000, adcDoneRequestFlag};
    end
    else if (hitReg(paddr, `ASC_OFF_MASK))
    begin
      prdata = {31'h00000000, adcIrqMask};
    end
    else if (paddr[7:4] == 4'h1)
    begin
      prdata = {24'h000000, slotRdData};
    end
    else if (hitReg(paddr, `ASC_OFF_EDGE))
    begin
      prdata = {28'h0000000, edgeFlag};
    end
    else if (hitReg(paddr, `ASC_OFF_STATE))
    begin
      prdata = {27'h0000000, refSync2, slotPtr, state};
    end
    else
    begin
      prdata = 32'h00000000;
    end
  end
endmodule // asc_sequencer

// File: rtl/asc_defines.vh
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ASC_OFF_MODE    8'h00
`define ASC_OFF_STATUS  8'h04
`define ASC_OFF_MASK    8'h08
`define ASC_OFF_SLOT0   8'h10
`define ASC_OFF_SLOT1   8'h14
`define ASC_OFF_SLOT2   8'h18
`define ASC_OFF_SLOT3   8'h1c
`define ASC_OFF_EDGE    8'h20
`define ASC_OFF_STATE   8'h24
// ----------------------------------------
// Mode register fields and reset values
// ----------------------------------------
`define ASC_MODE_SCAN_BIT  0
`define ASC_MODE_SEL_LSB   1
`define ASC_MODE_GROUP_BIT 3
`define ASC_MODE_FR_BIT    4
`define ASC_MODE_RESET     8'h00
`define ASC_MASK_RESET     1'b1
// ----------------------------------------
// Timing
// ----------------------------------------
`define ASC_SAMPLE_CYCLES  4'h4
`endif

// File: rtl/asc_slot_mem.v
`timescale 1ns/100ps
module asc_slot_mem
#(
  parameter DATA_W = 8,
  parameter ADDR_W = 2
)
(
  input  wire              clk,
  input  wire              wrEn,
  input  wire [ADDR_W-1:0] wrAddr,
  input  wire [DATA_W-1:0] wrData,
  input  wire [ADDR_W-1:0] rdAddr,
  output reg  [DATA_W-1:0] rdData
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ----------------------------------------
  // Storage, registered read
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // asc_slot_mem

// File: bench/asc_analog_model.sv
`timescale 1ns/100ps
module asc_analog_model
(
  input  wire [2:0] ainSelect,
  input  wire [7:0] dacTrial,
  output wire       cmpHigh
);
  // --------
  // Analog levels behind the mux
  // --------
  // Range ends catch an off-by-one in the trial loop
  function [7:0] level(input [2:0] ch);
    level = (ch == 3'h0) ? 8'h00 : (ch == 3'h7) ? 8'hff : {1'h0, ch, 4'h5};
  endfunction
  assign cmpHigh = level(ainSelect) >= dacTrial;
endmodule // asc_analog_model

// File: bench/asc_sequencer_props.sv
`timescale 1ns/100ps
`include "asc_defines.vh"
module asc_sequencer_props
#(
  parameter RES_W = 8
)
(
  input wire             clk,
  input wire             reset_n,
  input wire             hwStop,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [7:0]       paddr,
  input wire [31:0]      pwdata,
  input wire             pready,
  input wire [31:0]      prdata,
  input wire             pslverr,
  input wire             referenceEnableInput,
  input wire [7:4]       ainDigital,
  input wire [2:0]       ainSelect,
  input wire             sampleHold,
  input wire [RES_W-1:0] dacTrial,
  input wire             cmpHigh,
  input wire             adcDoneIrq
);
  // --------
  // Properties
  // --------
  // Mode writes restart the sequence, so timing checks step aside then
  wire modeWr = psel && pwrite && (paddr == `ASC_OFF_MODE);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_RESET_OUT: assert property ($rose(reset_n) |-> ainSelect == 3'h0 && !sampleHold
    && dacTrial == 0 && !adcDoneIrq) else $error("Outputs not idle after reset");
  AST_APB_OK: assert property (pready && !pslverr) else $error("Bus answer not ready or error");
  AST_MODE_READ: assert property (psel && penable && !pwrite && paddr == `ASC_OFF_MODE
    |-> prdata[31:5] == 27'h0) else $error("Mode read upper bits not zero");
  AST_HALT: assert property ((!referenceEnableInput || hwStop)[*5]
    |-> !sampleHold && $stable(dacTrial)) else $error("Converter runs while halted");
  AST_SAMPLE_LEN: assert property (disable iff (!reset_n || !referenceEnableInput || modeWr || hwStop)
    $rose(sampleHold) |-> sampleHold[*4] ##1 !sampleHold) else $error("Sample length wrong");
  AST_CONV_LEN: assert property (disable iff (!reset_n || !referenceEnableInput || modeWr || hwStop)
    $fell(sampleHold) |-> !sampleHold[*8] ##3 sampleHold) else $error("Conversion length wrong");
  AST_AIN_STABLE: assert property (sampleHold && $past(sampleHold) |-> $stable(ainSelect))
    else $error("Input select moved while sampling");
  AST_IRQ_FALL: assert property ($fell(adcDoneIrq) |-> ($past(pwrite) && $past(penable))
    || $past(hwStop)) else $error("Interrupt dropped without a write");
endmodule // asc_sequencer_props
bind asc_sequencer asc_sequencer_props #(.RES_W(RES_W)) u_asc_sequencer_props (.clk(clk),
  .reset_n(reset_n), .hwStop(hwStop), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .referenceEnableInput(referenceEnableInput), .ainDigital(ainDigital), .ainSelect(ainSelect),
  .sampleHold(sampleHold), .dacTrial(dacTrial), .cmpHigh(cmpHigh), .adcDoneIrq(adcDoneIrq));

// File: bench/test_asc_sequencer.sv
`timescale 1ns/100ps
`include "asc_defines.vh"
module test_asc_sequencer;
  reg         clk = 1'h0;
  reg         reset_n = 1'h0;
  reg         hwStop = 1'h0;
  reg         psel = 1'h0;
  reg         penable = 1'h0;
  reg         pwrite = 1'h0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         refEn = 1'h1;
  reg  [7:4]  ainDig = 4'hf;
  reg  [31:0] rd;
  wire        pready, pslverr, sampleHold, cmpHigh, adcDoneIrq;
  wire [31:0] prdata;
  wire [2:0]  ainSelect;
  wire [7:0]  dacTrial;
  integer     mismatches = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  integer     i, c;
  always #2.5 clk = ~clk;
  asc_sequencer u_asc_sequencer (.clk(clk), .reset_n(reset_n), .hwStop(hwStop), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .referenceEnableInput(refEn), .ainDigital(ainDig),
    .ainSelect(ainSelect), .sampleHold(sampleHold), .dacTrial(dacTrial), .cmpHigh(cmpHigh),
    .adcDoneIrq(adcDoneIrq));
  asc_analog_model u_asc_analog_model (.ainSelect(ainSelect), .dacTrial(dacTrial),
    .cmpHigh(cmpHigh));
  // --------
  // Shared tasks
  // --------
  function [7:0] lv(input [2:0] ch);
    lv = (ch == 3'h0) ? 8'h00 : (ch == 3'h7) ? 8'hff : {1'h0, ch, 4'h5};
  endfunction
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1)
        @(posedge clk);
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  // Clears the flag first so a stale round cannot pass for a fresh one
  task wait_done;
    begin
      apb(1'h1, `ASC_OFF_STATUS, 32'h1);
      rd = 32'h0;
      while (rd[0] !== 1'h1)
        apb(1'h0, `ASC_OFF_STATUS, 32'h0);
    end
  endtask
  task slots(input [2:0] b, input s);
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        apb(1'h0, 8'h10 | {i[1:0], 2'h0}, 32'h0);
        check("slot", rd, {24'h0, lv(s ? b + i[2:0] : b)});
      end
    end
  endtask
  // --------
  // Scenarios
  // --------
  task t_reset;
    begin
      apb(1'h0, `ASC_OFF_MODE, 32'h0);
      check("mode", rd, 32'h0);
      apb(1'h0, `ASC_OFF_MASK, 32'h0);
      check("mask", rd, 32'h1);
      apb(1'h1, 8'h3c, 32'hffffffff);
      apb(1'h0, 8'h3c, 32'h0);
      check("unmapped", rd, 32'h0);
      $display("t_reset end");
    end
  endtask
  task t_select;
    begin
      for (c = 0; c < 8; c = c + 1)
      begin
        apb(1'h1, `ASC_OFF_MODE, {28'h0, c[2:0], 1'h0});
        wait_done;
        slots(c[2:0], 1'h0);
      end
      $display("t_select end");
    end
  endtask
  task t_scan;
    begin
      for (c = 0; c < 2; c = c + 1)
      begin
        apb(1'h1, `ASC_OFF_MODE, c ? 32'hff : 32'h1);
        apb(1'h0, `ASC_OFF_MODE, 32'h0);
        check("mode", rd, c ? 32'h1f : 32'h1);
        wait_done;
        slots(c ? 3'h4 : 3'h0, 1'h1);
        wait_done;
        slots(c ? 3'h4 : 3'h0, 1'h1);
      end
      $display("t_scan end");
    end
  endtask
  task t_irq;
    begin
      wait_done;
      #1 check("irq", {31'h0, adcDoneIrq}, 32'h0);
      // Restart the round so no fresh set can land on the clear below
      apb(1'h1, `ASC_OFF_MODE, 32'h1f);
      apb(1'h1, `ASC_OFF_MASK, 32'h0);
      #1 check("irq", {31'h0, adcDoneIrq}, 32'h1);
      apb(1'h1, `ASC_OFF_STATUS, 32'h1);
      #1 check("irq", {31'h0, adcDoneIrq}, 32'h0);
      apb(1'h1, `ASC_OFF_MASK, 32'h1);
      $display("t_irq end");
    end
  endtask
  task t_ref;
    begin
      refEn <= 1'h0;
      repeat (20) @(posedge clk);
      check("hold", {31'h0, sampleHold}, 32'h0);
      ainDig <= 4'hd;
      repeat (6) @(posedge clk);
      apb(1'h0, `ASC_OFF_EDGE, 32'h0);
      check("edge", rd, 32'h2);
      apb(1'h0, `ASC_OFF_EDGE, 32'h0);
      check("edge", rd, 32'h0);
      apb(1'h0, `ASC_OFF_MODE, 32'h0);
      check("mode", rd, 32'h1f);
      refEn <= 1'h1;
      ainDig <= 4'hf;
      wait_done;
      slots(3'h4, 1'h1);
      $display("t_ref end");
    end
  endtask
  task t_stop;
    begin
      hwStop <= 1'h1;
      repeat (2) @(posedge clk);
      hwStop <= 1'h0;
      apb(1'h0, `ASC_OFF_MODE, 32'h0);
      check("mode", rd, 32'h0);
      apb(1'h0, `ASC_OFF_MASK, 32'h0);
      check("mask", rd, 32'h1);
      $display("t_stop end");
    end
  endtask
  task stop_test;
    begin
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    t_reset;
    t_select;
    t_scan;
    t_irq;
    t_ref;
    t_stop;
    stop_test;
  end
endmodule // test_asc_sequencer
